// file: verilog/osd_pkg.sv
// Shared constants and types for the character overlay generator
`default_nettype none
package osd_pkg;

  // ----------------------------------------------------------------
  // Geometry and storage
  // ----------------------------------------------------------------
  localparam int GLYPH_W = 12;
  localparam int GLYPH_H = 18;
  localparam int ROM_GLYPHS = 202;
  localparam int RAM_GLYPHS = 227;
  localparam int RAM_MC_MAX = 75;
  localparam int MC_PLANES = 3;
  localparam int GLYPH_BYTES = 27;
  localparam int FONT_BYTES = 6144;
  localparam int CMEM_DEPTH = 256;
  localparam int PAL_DEPTH = 16;
  localparam int MAX_WIN = 4;
  localparam int X_W = 11;
  localparam int ULINE_ROW = 17;
  localparam int ITALIC_SHIFT = 2;
  localparam logic [10:0] POS_FIRST = 11'h001;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint BLINK_HZ = 1;
  localparam longint BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);

  // ----------------------------------------------------------------
  // Palette
  // ----------------------------------------------------------------
  localparam logic [3:0] PAL_SHADOW = 4'h0;
  localparam logic [3:0] PAL_LIGHT = 4'h7;
  localparam logic [3:0] PAL_DARK = 4'h8;
  localparam logic [7:0] PAL_RST [PAL_DEPTH] = '{
    8'h00, 8'h03, 8'h1c, 8'h1f, 8'he0, 8'he3, 8'hfc, 8'hff,
    8'h49, 8'h02, 8'h10, 8'h12, 8'h80, 8'h82, 8'h90, 8'h92};
  localparam logic [7:0] RG_LEVEL [8] = '{
    8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'hff};
  localparam logic [7:0] B_LEVEL [4] = '{8'h00, 8'h40, 8'h80, 8'hff};

  // Red 3, green 3, blue 2 bits, msb first
  function automatic logic [23:0] pal_rgb(input logic [7:0] c);
    pal_rgb = {RG_LEVEL[c[7:5]], RG_LEVEL[c[4:2]], B_LEVEL[c[1:0]]};
  endfunction

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
    logic [23:0] rgb;
  } osd_pix_s;

  typedef struct packed {
    logic [3:0] fg;
    logic [3:0] bg;
    logic blink;
    logic italic;
    logic uline;
  } osd_attr_s;

  typedef struct packed {
    logic [7:0] code;
    osd_attr_s attr;
  } osd_char_s;

  typedef struct packed {
    logic en;
    logic use_ram;
    logic shadow_en;
    logic edge3d_en;
    logic [1:0] zoom_h;
    logic [1:0] zoom_v;
    logic [10:0] hstart;
    logic [10:0] vstart;
    logic [5:0] cols;
    logic [5:0] rows;
    logic [3:0] bg;
    logic [7:0] base;
  } osd_win_cfg_s;

  typedef struct packed {
    logic hit;
    logic in_glyph;
    logic edge_tl;
    logic edge_br;
    logic [3:0] gx;
    logic [4:0] gy;
    logic [7:0] idx;
  } osd_walk_s;

endpackage
`default_nettype wire

// file: verilog/osd_font_rom.sv
// Fixed glyph store, combinational lookup by code, column and row
`timescale 1ns/10ps
`default_nettype none
module osd_font_rom (
  input wire logic [7:0] i_code,
  input wire logic [3:0] i_gx,
  input wire logic [4:0] i_gy,
  output logic o_bit
);

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  // Stand-in art: code-dependent pattern inside a one-dot margin
  wire in_range = (i_code < 8'(osd_pkg::ROM_GLYPHS)) && (i_code != 8'h00);
  wire inner = (i_gx != 4'h0) && (i_gx < 4'(osd_pkg::GLYPH_W - 1)) &&
               (i_gy != 5'h00) && (i_gy < 5'(osd_pkg::GLYPH_H - 1));
  wire art = i_code[i_gx[2:0]] ^ i_gy[1];

  assign o_bit = in_range && inner && art;

endmodule
`default_nettype wire

// file: verilog/osd_win_walk.sv
// Per-window raster walker: cell, zoom and gap counters for one window
`timescale 1ns/10ps
`default_nettype none
module osd_win_walk (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire osd_pkg::osd_win_cfg_s i_cfg,
  input wire logic [3:0] i_hgap,
  input wire logic [3:0] i_vgap,
  input wire logic i_de,
  input wire logic [10:0] i_x,
  input wire logic i_line_end,
  input wire logic i_frame_start,
  input wire logic [10:0] i_y_next,
  output osd_pkg::osd_walk_s o_walk
);

  localparam logic [4:0] CW = 5'(osd_pkg::GLYPH_W);
  localparam logic [5:0] CH = 6'(osd_pkg::GLYPH_H);

  logic h_on_r;
  logic v_on_r;
  logic [1:0] hz_r;
  logic [1:0] vz_r;
  logic [4:0] px_r;
  logic [5:0] py_r;
  logic [5:0] col_r;
  logic [5:0] row_r;
  logic [7:0] rbase_r;

  // ----------------------------------------------------------------
  // Current-pixel view
  // ----------------------------------------------------------------
  // Start values of zero behave as the first pixel or line
  wire [10:0] hs = (i_cfg.hstart == '0) ? osd_pkg::POS_FIRST : i_cfg.hstart;
  wire [10:0] vs = (i_cfg.vstart == '0) ? osd_pkg::POS_FIRST : i_cfg.vstart;
  wire h_start = i_cfg.en && v_on_r && i_de && (i_x == hs);
  wire h_cur = h_start || (h_on_r && i_de);
  wire [1:0] hz = h_start ? 2'h0 : hz_r;
  wire [4:0] px = h_start ? 5'h00 : px_r;
  wire [5:0] col = h_start ? 6'h00 : col_r;
  wire hz_end = (hz == i_cfg.zoom_h);
  wire px_end = (px == CW + 5'(i_hgap) - 5'h01);
  wire col_end = (col + 6'h01 >= i_cfg.cols);
  wire vz_end = (vz_r == i_cfg.zoom_v);
  wire py_end = (py_r == CH + 6'(i_vgap) - 6'h01);
  wire row_end = (row_r + 6'h01 >= i_cfg.rows);
  wire v_load = i_cfg.en && (i_y_next == vs);

  assign o_walk.hit = h_cur;
  assign o_walk.in_glyph = (px < CW) && (py_r < CH);
  assign o_walk.gx = px[3:0];
  assign o_walk.gy = py_r[4:0];
  assign o_walk.idx = i_cfg.base + rbase_r + 8'(col);
  assign o_walk.edge_tl = h_start || (row_r == '0 && py_r == '0 && vz_r == '0);
  assign o_walk.edge_br = (hz_end && px_end && col_end) || (row_end && py_end && vz_end);

  // ----------------------------------------------------------------
  // Horizontal counters, stepped on every covered pixel
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      h_on_r <= 1'b0;
      hz_r <= 2'h0;
      px_r <= 5'h00;
      col_r <= 6'h00;
    end else begin
      h_on_r <= h_cur && !(hz_end && px_end && col_end);
      if (h_cur) begin
        hz_r <= hz_end ? 2'h0 : hz + 2'h1;
        px_r <= !hz_end ? px : (px_end ? 5'h00 : px + 5'h01);
        col_r <= (hz_end && px_end) ? col + 6'h01 : col;
      end
    end
  end

  // ----------------------------------------------------------------
  // Vertical counters, stepped at each line end
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      v_on_r <= 1'b0;
      vz_r <= 2'h0;
      py_r <= 6'h00;
      row_r <= 6'h00;
      rbase_r <= 8'h00;
    end else if (i_line_end || i_frame_start) begin
      if (v_load) begin
        v_on_r <= 1'b1;
        vz_r <= 2'h0;
        py_r <= 6'h00;
        row_r <= 6'h00;
        rbase_r <= 8'h00;
      end else if (i_frame_start) begin
        v_on_r <= 1'b0;
      end else if (v_on_r) begin
        vz_r <= vz_end ? 2'h0 : vz_r + 2'h1;
        if (vz_end) begin
          py_r <= py_end ? 6'h00 : py_r + 6'h01;
          if (py_end) begin
            row_r <= row_r + 6'h01;
            rbase_r <= rbase_r + 8'(i_cfg.cols);
            v_on_r <= !row_end;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/osd_overlay.sv
// Character overlay generator: memories, palette, window walkers and pixel mixer
`timescale 1ns/10ps
`default_nettype none
module osd_overlay #(
  parameter int NUM_WIN = 4,
  parameter int BLINK_HALF_CYC = int'(osd_pkg::BLINK_HALF_CYC)
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire osd_pkg::osd_pix_s i_vid,
  input wire osd_pkg::osd_win_cfg_s [NUM_WIN-1:0] i_win_cfg,
  input wire logic [3:0] i_hgap,
  input wire logic [3:0] i_vgap,
  input wire logic [7:0] i_mc_start,
  input wire logic i_cmem_we,
  input wire logic [7:0] i_cmem_addr,
  input wire osd_pkg::osd_char_s i_cmem_data,
  input wire logic i_font_we,
  input wire logic [12:0] i_font_addr,
  input wire logic [7:0] i_font_data,
  input wire logic i_pal_we,
  input wire logic [3:0] i_pal_idx,
  input wire logic [7:0] i_pal_data,
  output osd_pkg::osd_pix_s o_vid,
  output logic o_osd_active,
  output logic o_blink_phase
);

  localparam int BW = $clog2(BLINK_HALF_CYC + 1);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_WIN < 1 || NUM_WIN > osd_pkg::MAX_WIN) begin : g_bad_win
    $error("NUM_WIN must lie between 1 and 4");
  end
  if (BLINK_HALF_CYC < 2) begin : g_bad_blink
    $error("BLINK_HALF_CYC must be at least 2");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  osd_pkg::osd_char_s cmem_r [osd_pkg::CMEM_DEPTH];
  logic [7:0] font_r [osd_pkg::FONT_BYTES];
  logic [7:0] pal_r [osd_pkg::PAL_DEPTH];
  osd_pkg::osd_pix_s vid_r;
  logic active_r;
  logic blink_vis_r;
  logic [BW-1:0] blink_cnt_r;
  logic de_d_r;
  logic vs_d_r;
  logic [10:0] x_r;
  logic [10:0] y_r;

  // Character memory, shared by all windows
  always_ff @(posedge i_clk) begin
    if (i_cmem_we) begin
      cmem_r[i_cmem_addr] <= i_cmem_data;
    end
  end

  // Glyph RAM; writes past the top are dropped
  always_ff @(posedge i_clk) begin
    if (i_font_we && (i_font_addr < 13'(osd_pkg::FONT_BYTES))) begin
      font_r[i_font_addr] <= i_font_data;
    end
  end

  // Palette, reset to the default colour set
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      for (int k = 0; k < osd_pkg::PAL_DEPTH; k++) begin
        pal_r[k] <= osd_pkg::PAL_RST[k];
      end
    end else if (i_pal_we) begin
      pal_r[i_pal_idx] <= i_pal_data;
    end
  end

  // ----------------------------------------------------------------
  // Raster position
  // ----------------------------------------------------------------
  // Counted at the panel side so crop and scale never move windows
  wire [10:0] x_cur = de_d_r ? x_r + 11'h001 : osd_pkg::POS_FIRST;
  wire line_end = de_d_r && !i_vid.de;
  wire frame_start = i_vid.vs && !vs_d_r;
  wire [10:0] y_next = frame_start ? osd_pkg::POS_FIRST : y_r + 11'h001;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      de_d_r <= 1'b0;
      vs_d_r <= 1'b0;
      x_r <= 11'h000;
      y_r <= 11'h000;
    end else begin
      de_d_r <= i_vid.de;
      vs_d_r <= i_vid.vs;
      if (i_vid.de) begin
        x_r <= x_cur;
      end
      if (line_end || frame_start) begin
        y_r <= y_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Blink timer
  // ----------------------------------------------------------------
  // Clock-based so the rate holds for any panel size or frame rate
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      blink_cnt_r <= '0;
      blink_vis_r <= 1'b1;
    end else if (blink_cnt_r == BLINK_LAST) begin
      blink_cnt_r <= '0;
      blink_vis_r <= !blink_vis_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + BW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Window walkers
  // ----------------------------------------------------------------
  osd_pkg::osd_walk_s walk [osd_pkg::MAX_WIN];
  logic [osd_pkg::MAX_WIN-1:0] hits;

  for (genvar g = 0; g < osd_pkg::MAX_WIN; g++) begin : g_win
    if (g < NUM_WIN) begin : g_on
      osd_win_walk u_walk (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_cfg(i_win_cfg[g]),
        .i_hgap(i_hgap),
        .i_vgap(i_vgap),
        .i_de(i_vid.de),
        .i_x(x_cur),
        .i_line_end(line_end),
        .i_frame_start(frame_start),
        .i_y_next(y_next),
        .o_walk(walk[g])
      );
    end else begin : g_off
      assign walk[g] = '0;
    end
    assign hits[g] = walk[g].hit;
  end

  // Lowest-numbered window wins where windows overlap
  function automatic logic [1:0] pick_win(input logic [3:0] h);
    pick_win = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (h[k]) begin
        pick_win = 2'(k);
      end
    end
  endfunction

  wire [1:0] sel = pick_win(hits);
  wire any_hit = |hits;
  osd_pkg::osd_walk_s w;
  osd_pkg::osd_win_cfg_s wcfg;
  osd_pkg::osd_char_s ch;
  assign w = walk[sel];
  assign wcfg = i_win_cfg[sel];
  assign ch = cmem_r[w.idx];

  // ----------------------------------------------------------------
  // Glyph lookup
  // ----------------------------------------------------------------
  // Bit address: slot times 27 bytes, then row-major 12-dot rows
  function automatic logic ram_bit(input logic [9:0] slot, input logic [3:0] gx, input logic [4:0] gy);
    logic [7:0] pos;
    logic [12:0] addr;
    pos = 8'(gy) * 8'(osd_pkg::GLYPH_W) + 8'(gx);
    addr = 13'(slot) * 13'(osd_pkg::GLYPH_BYTES) + 13'(pos[7:3]);
    ram_bit = (slot < 10'(osd_pkg::RAM_GLYPHS)) ? font_r[addr][3'h7 - pos[2:0]] : 1'b0;
  endfunction

  // Slant right toward the top; dots pushed past the cell are lost
  wire [4:0] it_shift = 5'(osd_pkg::GLYPH_H - 1) - w.gy;
  wire [4:0] it_amt = it_shift >> osd_pkg::ITALIC_SHIFT;
  wire [4:0] gx_w = {1'b0, w.gx};
  wire it_out = ch.attr.italic && (gx_w < it_amt);
  wire [3:0] gx_s = ch.attr.italic ? 4'(gx_w - it_amt) : w.gx;
  wire uline = ch.attr.uline && (w.gy == 5'(osd_pkg::ULINE_ROW));

  // In glyph RAM windows, codes at or above the split point are three-plane colour sets
  wire ch_mc = wcfg.use_ram && (ch.code >= i_mc_start);
  wire [7:0] mc_set = ch.code - i_mc_start;
  wire [9:0] mc_slot = 10'(i_mc_start) + 10'(mc_set) * 10'(osd_pkg::MC_PLANES);
  wire [2:0] mc_pix = {ram_bit(mc_slot, gx_s, w.gy),
                       ram_bit(mc_slot + 10'h001, gx_s, w.gy),
                       ram_bit(mc_slot + 10'h002, gx_s, w.gy)};
  wire sc_bit = ram_bit(10'(ch.code), gx_s, w.gy);
  wire rom_bit;

  osd_font_rom u_rom (
    .i_code(ch.code),
    .i_gx(gx_s),
    .i_gy(w.gy),
    .o_bit(rom_bit)
  );

  // ----------------------------------------------------------------
  // Colour selection
  // ----------------------------------------------------------------
  wire char_on = !ch.attr.blink || blink_vis_r;
  wire glyph_bit = !it_out && (wcfg.use_ram ? sc_bit : rom_bit);
  wire fg_on = (glyph_bit || uline) && char_on;
  wire mc_on = !it_out && (mc_pix != 3'h0) && char_on;
  wire [3:0] glyph_col = ch_mc ? (mc_on ? {1'b0, mc_pix} : ch.attr.bg)
                               : (fg_on ? ch.attr.fg : ch.attr.bg);
  wire [3:0] body_col = w.in_glyph ? glyph_col : wcfg.bg;
  wire edge_3d = wcfg.edge3d_en && (w.edge_tl || w.edge_br);
  wire edge_sh = wcfg.shadow_en && w.edge_br;
  wire edge_sel = edge_3d || edge_sh;
  wire [3:0] edge_col = edge_3d ? (w.edge_tl ? osd_pkg::PAL_LIGHT : osd_pkg::PAL_DARK)
                                : osd_pkg::PAL_SHADOW;
  wire [3:0] col_idx = edge_sel ? edge_col : body_col;
  wire [23:0] osd_rgb = osd_pkg::pal_rgb(pal_r[col_idx]);

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // One register for all fields keeps syncs and colour aligned
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      vid_r <= '0;
      active_r <= 1'b0;
    end else begin
      vid_r.de <= i_vid.de;
      vid_r.hs <= i_vid.hs;
      vid_r.vs <= i_vid.vs;
      vid_r.rgb <= any_hit ? osd_rgb : i_vid.rgb;
      active_r <= any_hit;
    end
  end

  assign o_vid = vid_r;
  assign o_osd_active = active_r;
  assign o_blink_phase = blink_vis_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_sync_pass: assert property (
    $past(i_rstn) |-> (o_vid.de == $past(i_vid.de)) && (o_vid.hs == $past(i_vid.hs)) &&
                      (o_vid.vs == $past(i_vid.vs)))
    else $error("sync fields not delayed by exactly one cycle");

  a_video_pass: assert property (
    $past(i_rstn) && !$past(any_hit) |-> (o_vid.rgb == $past(i_vid.rgb)) && !o_osd_active)
    else $error("video altered outside windows");

  a_overlay_fill: assert property (
    $past(i_rstn) && $past(any_hit) |-> (o_vid.rgb == $past(osd_rgb)) && o_osd_active)
    else $error("window pixel not replaced by overlay colour");

  a_pal_store: assert property (
    $past(i_rstn) && $past(i_pal_we) |-> pal_r[$past(i_pal_idx)] == $past(i_pal_data))
    else $error("palette write not stored");

  a_blink_flip: assert property (
    (blink_cnt_r == BLINK_LAST) |=> (o_blink_phase != $past(o_blink_phase)) && (blink_cnt_r == '0))
    else $error("blink phase did not flip at period end");

  a_blink_hold: assert property (
    (blink_cnt_r != BLINK_LAST) |=> $stable(o_blink_phase))
    else $error("blink phase changed mid period");

  a_rom_limit: assert property (
    (ch.code >= 8'(osd_pkg::ROM_GLYPHS)) |-> !rom_bit)
    else $error("fixed store lit a dot for an unused code");

  a_glyph_cell: assert property (
    any_hit && w.in_glyph |-> (w.gx < 4'(osd_pkg::GLYPH_W)) && (w.gy < 5'(osd_pkg::GLYPH_H)))
    else $error("glyph dot outside the 12 by 18 cell");

  a_win_first: assert property (
    hits[0] |-> (sel == 2'h0))
    else $error("window 0 lost priority");

  a_uline_row: assert property (
    any_hit && w.in_glyph && !ch_mc && !edge_sel && uline && char_on |-> col_idx == ch.attr.fg)
    else $error("underline row not in foreground colour");

  a_win_back: assert property (
    any_hit && !w.in_glyph && !edge_sel |-> col_idx == wcfg.bg)
    else $error("gap pixel not in window background colour");

  c_italic_char: cover property (any_hit && w.in_glyph && ch.attr.italic && fg_on);
  c_multi_colour: cover property (any_hit && ch_mc && mc_on);
  c_two_windows: cover property (hits[0] && hits[1]);
  c_blink_hidden: cover property (any_hit && ch.attr.blink && !blink_vis_r);

endmodule
`default_nettype wire

// file: verification/osd_vid_src.sv
// Panel pixel source model: raster timing, position and video pattern
`timescale 1ns/10ps
`default_nettype none
module osd_vid_src #(
  parameter int W = 48,
  parameter int H = 30
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  output osd_pkg::osd_pix_s o_pix,
  output logic [10:0] o_x,
  output logic [10:0] o_y
);
  int h = 0;
  int v = 0;
  logic de;
  // Eight blank cycles per line, line 0 is the sync line
  always @(posedge i_clk) begin
    h <= (!i_rstn || h == W + 7) ? 0 : h + 1;
    if (!i_rstn) begin
      v <= 0;
    end else if (h == W + 7) begin
      v <= (v == H) ? 0 : v + 1;
    end
  end
  // Blanking rgb keeps moving so a stale value never passes for video
  assign de = v > 0 && h < W;
  assign o_x = 11'(h + 1);
  assign o_y = 11'(v);
  assign o_pix = {de, h >= W + 2 && h < W + 5, v == 0, de ? {8'(v), 8'(h), 8'h5a} : {8'(~h), 8'h33, 8'(h * 7)}};
endmodule
`default_nettype wire

// file: verification/osd_overlay_tb.sv
// Self-checking bench for the character overlay generator
`timescale 1ns/10ps
`default_nettype none
module osd_overlay_tb;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  wire osd_pkg::osd_pix_s i_vid;
  osd_pkg::osd_win_cfg_s [3:0] i_win_cfg = '0;
  logic [3:0] i_hgap = 4'h0;
  logic [3:0] i_vgap = 4'h0;
  logic [7:0] i_mc_start = 8'hff;
  logic i_cmem_we = 1'b0;
  logic [7:0] i_cmem_addr = 8'h00;
  osd_pkg::osd_char_s i_cmem_data = '0;
  logic i_font_we = 1'b0;
  logic [12:0] i_font_addr = 13'h0000;
  logic [7:0] i_font_data = 8'h00;
  logic i_pal_we = 1'b0;
  logic [3:0] i_pal_idx = 4'h0;
  logic [7:0] i_pal_data = 8'h00;
  osd_pkg::osd_pix_s o_vid;
  logic o_osd_active;
  logic o_blink_phase;
  wire logic [10:0] src_x;
  wire logic [10:0] src_y;
  osd_pkg::osd_pix_s pin;
  osd_pkg::osd_pix_s pout;
  logic pact;
  osd_pkg::osd_win_cfg_s wcfg;
  int fails = 0;
  int n_compared = 0;

  always #4 i_clk = ~i_clk;

  osd_vid_src osd_vid_src_i (.i_clk, .i_rstn, .o_pix(i_vid), .o_x(src_x), .o_y(src_y));
  osd_overlay #(.NUM_WIN(4), .BLINK_HALF_CYC(8)) osd_overlay_i (.i_clk, .i_rstn, .i_vid, .i_win_cfg,
    .i_hgap, .i_vgap, .i_mc_start, .i_cmem_we, .i_cmem_addr, .i_cmem_data, .i_font_we, .i_font_addr,
    .i_font_data, .i_pal_we, .i_pal_idx, .i_pal_data, .o_vid, .o_osd_active, .o_blink_phase);

  // Palette code to 24-bit colour, worked out independently
  function automatic logic [23:0] rgb332(input logic [7:0] c);
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    r = (c[7:5] == 3'h7) ? 8'hff : {c[7:5], 5'h00};
    g = (c[4:2] == 3'h7) ? 8'hff : {c[4:2], 5'h00};
    b = (c[1:0] == 2'h3) ? 8'hff : {c[1:0], 6'h00};
    return {r, g, b};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write pulse: 0 char memory, 1 glyph RAM, 2 palette
  task automatic wr(input int sel, input logic [12:0] a, input logic [18:0] d);
    @(posedge i_clk);
    i_cmem_we <= sel == 0;
    i_font_we <= sel == 1;
    i_pal_we <= sel == 2;
    i_cmem_addr <= a[7:0];
    i_cmem_data <= d;
    i_font_addr <= a;
    i_font_data <= d[7:0];
    i_pal_idx <= a[3:0];
    i_pal_data <= d[7:0];
    @(posedge i_clk);
    {i_cmem_we, i_font_we, i_pal_we} <= 3'b000;
  endtask

  // Wait for a raster position, then take the registered output
  task automatic see(input logic [10:0] x, input logic [10:0] y, input logic [7:0] c, input logic act);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (!(src_x == x && src_y == y && i_vid.de === 1'b1) && n < 4000);
    pin = i_vid;
    @(posedge i_clk);
    #1;
    pout = o_vid;
    pact = o_osd_active;
    chk("pixel reached", 32'd1, 32'(n < 4000));
    chk("active", 32'(act), 32'(pact));
    chk("rgb", act ? 32'(rgb332(c)) : 32'(pin.rgb), 32'(pout.rgb));
    chk("sync", 32'(pin[26:24]), 32'(pout[26:24]));
  endtask

  task automatic t_window;
    wr(2, 13'h0005, 19'h0006d);
    wr(0, 13'h0000, {8'h00, 4'h3, 4'h5, 3'b000});
    wr(0, 13'h0001, {8'h02, 4'h6, 4'h5, 3'b000});
    wcfg = '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 11'h005, 11'h003, 6'h02, 6'h01, 4'h9, 8'h00};
    @(posedge i_clk);
    i_win_cfg[0] <= wcfg;
    i_hgap <= 4'h2;
    // Rows load at a line end, so start from a fresh frame
    @(posedge i_clk iff src_y == 11'd0);
    see(11'd4, 11'd3, 8'h00, 1'b0);
    see(11'd5, 11'd3, 8'h6d, 1'b1);
    see(11'd17, 11'd3, 8'h02, 1'b1);
    see(11'd33, 11'd3, 8'h00, 1'b0);
    see(11'd20, 11'd4, 8'hfc, 1'b1);
    see(11'd5, 11'd21, 8'h00, 1'b0);
    $display("window test done");
  endtask

  task automatic t_ram;
    wr(1, 13'h001b, 19'h00080);
    wr(0, 13'h0004, {8'h01, 4'h3, 4'h5, 3'b000});
    wcfg.use_ram = 1'b1;
    wcfg.zoom_h = 2'h1;
    wcfg.base = 8'h04;
    @(posedge i_clk);
    i_win_cfg[0] <= wcfg;
    see(11'd5, 11'd3, 8'h1f, 1'b1);
    see(11'd6, 11'd3, 8'h1f, 1'b1);
    see(11'd7, 11'd3, 8'h6d, 1'b1);
    $display("glyph ram test done");
  endtask

  // Edges, italic, underline, colour sets, memory wrap and a second window
  task automatic t_attr;
    wr(1, 13'h001c, 19'h00008);
    wr(1, 13'h0034, 19'h00000);
    wr(1, 13'h0037, 19'h00008);
    wr(1, 13'h0052, 19'h00008);
    wr(1, 13'h006d, 19'h00000);
    wr(0, 13'h00ff, {8'h01, 4'h3, 4'h5, 3'b011});
    wr(0, 13'h0000, {8'h02, 4'h3, 4'h5, 3'b000});
    @(posedge i_clk);
    i_mc_start <= 8'h02;
    i_vgap <= 4'h1;
    i_win_cfg[0] <= '{1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 11'd5, 11'd3, 6'h02, 6'h01, 4'h9, 8'hff};
    i_win_cfg[1] <= '{1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 11'd30, 11'd3, 6'h01, 6'h01, 4'h4, 8'h00};
    @(posedge i_clk iff src_y == 11'd0);
    see(11'd5, 11'd3, 8'hff, 1'b1);
    see(11'd6, 11'd4, 8'h6d, 1'b1);
    see(11'd9, 11'd4, 8'h1f, 1'b1);
    see(11'd19, 11'd4, 8'hfc, 1'b1);
    see(11'd31, 11'd5, 8'h02, 1'b1);
    see(11'd42, 11'd5, 8'he0, 1'b1);
    see(11'd43, 11'd5, 8'h00, 1'b1);
    see(11'd6, 11'd20, 8'h1f, 1'b1);
    see(11'd6, 11'd21, 8'h49, 1'b1);
    $display("attribute test done");
  endtask

  // First pass aligns to a toggle, second measures a whole half period
  task automatic t_blink;
    int n;
    logic p;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      p = o_blink_phase;
      while (o_blink_phase === p && n < 40) begin
        @(negedge i_clk);
        n++;
      end
    end
    chk("blink half period", 32'd8, 32'(n));
    $display("blink test done");
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (19) @(posedge i_clk);
    #1;
    chk("reset vid", 32'd0, 32'(o_vid));
    chk("reset active", 32'd0, 32'(o_osd_active));
    chk("reset blink", 32'd1, 32'(o_blink_phase));
    @(posedge i_clk);
    i_rstn <= 1'b1;
    $display("reset test done");
    see(11'd1, 11'd1, 8'h00, 1'b0);
    see(11'd48, 11'd2, 8'h00, 1'b0);
    $display("pass-through test done");
    t_window();
    t_ram();
    t_attr();
    t_blink();
    final_report();
  end

  // Hang guard, about six times the expected run
  initial begin
    repeat (40000) @(posedge i_clk);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
